// *** logic/jsb_dev.sv ***
// Device end: TAP controller with the four service bus access instructions
// and a service bus master on the user side.
// Assumes tck from the link is far slower than mclk (at least 6 mclk per phase).
//
// Behaviour
// - 0x10 selects 34-bit debug register chain
// - 0x14 selects 34-bit memory-service register chain
// - 0x15 selects 39-bit sized memory chain
// - 0x11 selects 35-bit word memory chain
// - Address first; toggle on non-busy scan end
// - Direction bit one reads, zero writes
// - Debugger walks Idle, address, Update, data
// - Debugger shifts every address bit
// - Write data scans carry all 32 bits
// - Read data scans may be cut short
// - Read scan returns data, busy, error
// - Write scan stores data, output meaningless
// - Size codes byte, halfword, word, reserved
// - Lanes follow address modulo four, aligned
// - Targets may accept word accesses only
// - Busy flag shows outstanding bus access
// - Error flag shows failed bus access
// - Fields shift least significant bit first
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`default_nettype none
module jsb_dev (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // JTAG link
  jsb_link_if.dev          link,
  // Service bus master
  output logic             sab_req,
  output logic [1:0]       sab_unit,
  output logic [35:0]      sab_addr,
  output logic             sab_write,
  output logic [3:0]       sab_be,
  output logic [31:0]      sab_wdata,
  input  wire logic        sab_ack,
  input  wire logic        sab_err,
  input  wire logic [31:0] sab_rdata
);
  typedef struct packed {
    logic                  tck_m;
    logic                  tck_s;
    logic                  tck_d;
    logic                  tms_m;
    logic                  tms_s;
    logic                  tdi_m;
    logic                  tdi_s;
    jsb_pkg::jsb_tap_e     tap;
    logic [4:0]            ir;
    logic [4:0]            ir_sr;
    logic [38:0]           dr;
    logic                  byp;
    logic                  addr_phase;
    logic                  cap_busy;
    logic                  rd;
    logic [1:0]            size;
    logic [35:0]           addr;
    logic                  busy;
    logic                  err;
    logic [31:0]           rdata;
    logic                  tdo;
    logic                  req;
    logic [1:0]            unit;
    logic                  write;
    logic [3:0]            be;
    logic [31:0]           wdata;
  } jsb_dev_s;

  jsb_dev_s q;
  jsb_dev_s d;

  logic       rise;
  logic       fall;
  logic       acc;
  logic       go;
  logic       bad;
  logic [5:0] len;

  function automatic jsb_pkg::jsb_tap_e tap_next(input jsb_pkg::jsb_tap_e s, input logic tms);
    unique case (s)
      jsb_pkg::TAP_RESET:    tap_next = tms ? jsb_pkg::TAP_RESET    : jsb_pkg::TAP_IDLE;
      jsb_pkg::TAP_IDLE:     tap_next = tms ? jsb_pkg::TAP_SEL_DR   : jsb_pkg::TAP_IDLE;
      jsb_pkg::TAP_SEL_DR:   tap_next = tms ? jsb_pkg::TAP_SEL_IR   : jsb_pkg::TAP_CAP_DR;
      jsb_pkg::TAP_CAP_DR:   tap_next = tms ? jsb_pkg::TAP_EXIT1_DR : jsb_pkg::TAP_SHIFT_DR;
      jsb_pkg::TAP_SHIFT_DR: tap_next = tms ? jsb_pkg::TAP_EXIT1_DR : jsb_pkg::TAP_SHIFT_DR;
      jsb_pkg::TAP_EXIT1_DR: tap_next = tms ? jsb_pkg::TAP_UPD_DR   : jsb_pkg::TAP_PAUSE_DR;
      jsb_pkg::TAP_PAUSE_DR: tap_next = tms ? jsb_pkg::TAP_EXIT2_DR : jsb_pkg::TAP_PAUSE_DR;
      jsb_pkg::TAP_EXIT2_DR: tap_next = tms ? jsb_pkg::TAP_UPD_DR   : jsb_pkg::TAP_SHIFT_DR;
      jsb_pkg::TAP_UPD_DR:   tap_next = tms ? jsb_pkg::TAP_SEL_DR   : jsb_pkg::TAP_IDLE;
      jsb_pkg::TAP_SEL_IR:   tap_next = tms ? jsb_pkg::TAP_RESET    : jsb_pkg::TAP_CAP_IR;
      jsb_pkg::TAP_CAP_IR:   tap_next = tms ? jsb_pkg::TAP_EXIT1_IR : jsb_pkg::TAP_SHIFT_IR;
      jsb_pkg::TAP_SHIFT_IR: tap_next = tms ? jsb_pkg::TAP_EXIT1_IR : jsb_pkg::TAP_SHIFT_IR;
      jsb_pkg::TAP_EXIT1_IR: tap_next = tms ? jsb_pkg::TAP_UPD_IR   : jsb_pkg::TAP_PAUSE_IR;
      jsb_pkg::TAP_PAUSE_IR: tap_next = tms ? jsb_pkg::TAP_EXIT2_IR : jsb_pkg::TAP_PAUSE_IR;
      jsb_pkg::TAP_EXIT2_IR: tap_next = tms ? jsb_pkg::TAP_UPD_IR   : jsb_pkg::TAP_SHIFT_IR;
      jsb_pkg::TAP_UPD_IR:   tap_next = tms ? jsb_pkg::TAP_SEL_DR   : jsb_pkg::TAP_IDLE;
    endcase
  endfunction

  always_comb
  begin
    d    = q;
    go   = 1'b0;
    bad  = 1'b0;
    // Edges are taken from the second and third stages, never the first
    rise = q.tck_s & ~q.tck_d;
    fall = ~q.tck_s & q.tck_d;
    acc  = (q.ir == jsb_pkg::IR_DEBUG_REG) || (q.ir == jsb_pkg::IR_MSU_REG) ||
           (q.ir == jsb_pkg::IR_MEM_SIZED) || (q.ir == jsb_pkg::IR_MEM_WORD);
    unique case (q.ir)
      jsb_pkg::IR_MEM_SIZED: len = jsb_pkg::LEN_SIZED;
      jsb_pkg::IR_MEM_WORD:  len = jsb_pkg::LEN_WORD;
      default:               len = jsb_pkg::LEN_REG;
    endcase
    d.tck_m = link.tck;
    d.tck_s = q.tck_m;
    d.tck_d = q.tck_s;
    d.tms_m = link.tms;
    d.tms_s = q.tms_m;
    d.tdi_m = link.tdi;
    d.tdi_s = q.tdi_m;

    if (q.req && sab_ack)
    begin
      d.req  = 1'b0;
      d.busy = 1'b0;
      d.err  = sab_err;
      if (q.rd)
        d.rdata = sab_rdata;
    end

    if (rise)
    begin
      d.tap = tap_next(q.tap, q.tms_s);
      unique case (q.tap)
        jsb_pkg::TAP_RESET:    d.ir = jsb_pkg::IR_BYPASS;
        jsb_pkg::TAP_CAP_IR:   d.ir_sr = {jsb_pkg::PROTECT_BIT, q.err, q.busy, jsb_pkg::IR_CAP_LOW};
        jsb_pkg::TAP_SHIFT_IR: d.ir_sr = {q.tdi_s, q.ir_sr[4:1]};
        jsb_pkg::TAP_UPD_IR:
        begin
          d.ir         = q.ir_sr;
          d.addr_phase = 1'b1;
        end
        jsb_pkg::TAP_CAP_DR:
        begin
          d.byp      = 1'b0;
          d.cap_busy = q.busy;
          d.dr       = '0;
          if (q.addr_phase)
          begin
            d.dr[jsb_pkg::ADDR_BUSY] = q.busy;
            d.dr[jsb_pkg::ADDR_ERR]  = q.err;
          end
          else
          begin
            d.dr[31:0]               = q.rdata;
            d.dr[jsb_pkg::DATA_BUSY] = q.busy;
            d.dr[jsb_pkg::DATA_ERR]  = q.err;
          end
        end
        jsb_pkg::TAP_SHIFT_DR:
        begin
          d.byp                  = q.tdi_s;
          // New bit enters at the top of the chain, so a cut-short scan is harmless
          d.dr                   = q.dr >> 1;
          d.dr[len - 6'h01]      = q.tdi_s;
        end
        jsb_pkg::TAP_UPD_DR:
        begin
          if (acc && !q.cap_busy)
          begin
            if (q.addr_phase)
            begin
              d.addr_phase = 1'b0;
              d.rd         = q.dr[jsb_pkg::DIR_BIT];
              d.size       = jsb_pkg::SIZE_WORD;
              unique case (q.ir)
                jsb_pkg::IR_MEM_SIZED:
                begin
                  d.unit = jsb_pkg::UNIT_MEM;
                  d.size = q.dr[jsb_pkg::SIZE_MSB:jsb_pkg::SIZE_LSB];
                  d.addr = q.dr[jsb_pkg::SADDR_MSB:jsb_pkg::SADDR_LSB];
                end
                jsb_pkg::IR_MEM_WORD:
                begin
                  d.unit = jsb_pkg::UNIT_MEM;
                  d.addr = {q.dr[jsb_pkg::WADDR_MSB:jsb_pkg::WADDR_LSB], 2'h0};
                end
                jsb_pkg::IR_MSU_REG:
                begin
                  d.unit = jsb_pkg::UNIT_MSU;
                  d.addr = {29'h0, q.dr[jsb_pkg::REG_IDX_MSB:jsb_pkg::REG_IDX_LSB]};
                end
                default:
                begin
                  d.unit = jsb_pkg::UNIT_DEBUG;
                  d.addr = {29'h0, q.dr[jsb_pkg::REG_IDX_MSB:jsb_pkg::REG_IDX_LSB]};
                end
              endcase
              // Reads start now so the data are ready for the data scan
              go = q.dr[jsb_pkg::DIR_BIT];
            end
            else
            begin
              d.addr_phase = 1'b1;
              if (!q.rd)
              begin
                d.wdata = q.dr[31:0];
                go      = 1'b1;
              end
            end
          end
        end
        default: ;
      endcase
    end

    if (go)
    begin
      // Register index units carry no size or lane, so only memory is checked
      bad = (d.unit == jsb_pkg::UNIT_MEM) &&
            ((d.size == jsb_pkg::SIZE_RSVD) ||
             ((d.size == jsb_pkg::SIZE_HALF) && d.addr[0]) ||
             ((d.size == jsb_pkg::SIZE_WORD) && (d.addr[1:0] != 2'h0)));
      unique case (d.size)
        jsb_pkg::SIZE_BYTE: d.be = 4'h1 << d.addr[1:0];
        jsb_pkg::SIZE_HALF: d.be = 4'h3 << d.addr[1:0];
        default:            d.be = 4'hf;
      endcase
      // Misaligned or reserved sizes never reach the bus; they just report an error
      d.err   = bad;
      d.req   = ~bad;
      d.busy  = ~bad;
      d.write = ~d.rd;
    end

    if (fall)
    begin
      if (q.tap == jsb_pkg::TAP_SHIFT_IR)
        d.tdo = q.ir_sr[0];
      else if (q.tap == jsb_pkg::TAP_SHIFT_DR)
        d.tdo = acc ? q.dr[0] : q.byp;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      q     <= '0;
      q.tap <= jsb_pkg::TAP_RESET;
      q.ir  <= jsb_pkg::IR_BYPASS;
    end
    else
      q <= d;
  end

  assign link.tdo  = q.tdo;
  assign sab_req   = q.req;
  assign sab_unit  = q.unit;
  assign sab_addr  = q.addr;
  assign sab_write = q.write;
  assign sab_be    = q.be;
  assign sab_wdata = q.wdata;
endmodule
`default_nettype wire

// *** logic/jsb_pkg.sv ***
// Shared constants for the JTAG service bus access port: instruction codes,
// chain lengths, field positions, size codes, host register offsets and timing.
// Assumes both ends and the bench compile this package first.
`default_nettype none
package jsb_pkg;
  // Instruction register
  localparam int          IR_LEN       = 5;
  localparam logic [4:0]  IR_DEBUG_REG = 5'h10;
  localparam logic [4:0]  IR_MSU_REG   = 5'h14;
  localparam logic [4:0]  IR_MEM_SIZED = 5'h15;
  localparam logic [4:0]  IR_MEM_WORD  = 5'h11;
  localparam logic [4:0]  IR_BYPASS    = 5'h1f;
  localparam logic [1:0]  IR_CAP_LOW   = 2'h1;
  localparam logic        PROTECT_BIT  = 1'h0;

  // Scan chain lengths, instruction and data
  localparam int          DR_MAX       = 39;
  localparam logic [5:0]  LEN_IR       = 6'h05;
  localparam logic [5:0]  LEN_REG      = 6'h22;
  localparam logic [5:0]  LEN_WORD     = 6'h23;
  localparam logic [5:0]  LEN_SIZED    = 6'h27;

  // Field positions in the data chain
  localparam int          DIR_BIT      = 0;
  localparam int          ADDR_BUSY    = 0;
  localparam int          ADDR_ERR     = 1;
  localparam int          DATA_BUSY    = 32;
  localparam int          DATA_ERR     = 33;
  localparam int          REG_IDX_LSB  = 1;
  localparam int          REG_IDX_MSB  = 7;
  localparam int          SIZE_LSB     = 1;
  localparam int          SIZE_MSB     = 2;
  localparam int          SADDR_LSB    = 3;
  localparam int          SADDR_MSB    = 38;
  localparam int          WADDR_LSB    = 1;
  localparam int          WADDR_MSB    = 34;

  // Access sizes
  localparam logic [1:0]  SIZE_BYTE    = 2'h0;
  localparam logic [1:0]  SIZE_HALF    = 2'h1;
  localparam logic [1:0]  SIZE_WORD    = 2'h2;
  localparam logic [1:0]  SIZE_RSVD    = 2'h3;

  // Service bus target units
  localparam logic [1:0]  UNIT_DEBUG   = 2'h0;
  localparam logic [1:0]  UNIT_MSU     = 2'h1;
  localparam logic [1:0]  UNIT_MEM     = 2'h2;

  // Host register offsets
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_ADDR_LO  = 4'h1;
  localparam logic [3:0]  REG_ADDR_HI  = 4'h2;
  localparam logic [3:0]  REG_WDATA    = 4'h3;
  localparam logic [3:0]  REG_START    = 4'h4;
  localparam logic [3:0]  REG_RDATA    = 4'h5;
  localparam logic [3:0]  REG_STATUS   = 4'h6;
  localparam logic [3:0]  REG_MASK     = 4'h7;

  // Test clock made by the host
  localparam int          MCLK_NS      = 10;
  localparam int          TCK_HALF_NS  = 80;
  localparam int          TCK_HALF_CYC = TCK_HALF_NS / MCLK_NS;
  localparam logic [3:0]  TCK_DIV_LAST = 4'(TCK_HALF_CYC - 1);

  // Mode select values for the host
  localparam logic [1:0]  SEL_DEBUG    = 2'h0;
  localparam logic [1:0]  SEL_MSU      = 2'h1;
  localparam logic [1:0]  SEL_SIZED    = 2'h2;
  localparam logic [1:0]  SEL_WORD     = 2'h3;

  // Lead-in TMS bits, first bit in bit 0
  localparam logic [4:0]  PRE_IR       = 5'h06;
  localparam logic [2:0]  PRE_IR_N     = 3'h5;
  localparam logic [4:0]  PRE_DR       = 5'h01;
  localparam logic [2:0]  PRE_DR_N     = 3'h3;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jsb_tap_e;
endpackage
`default_nettype wire

// *** logic/jsb_link_if.sv ***
// The four JTAG wires between the host controller and the device.
// Assumes one host and one device; the host makes the test clock.
`default_nettype none
interface jsb_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  modport dev  (input tck, input tms, input tdi, output tdo);
  modport host (output tck, output tms, output tdi, input tdo);
endinterface
`default_nettype wire

// *** logic/jsb_host.sv ***
// Host end: JTAG controller that runs one service bus access per start command.
// Assumes the device samples the link with its own clock; tck is made here.
`default_nettype none
module jsb_host (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // JTAG link
  jsb_link_if.host         link,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq
);
  typedef enum logic [2:0] {H_IDLE, H_PRE, H_SHIFT, H_POST, H_END} jsb_hst_e;
  typedef enum logic [1:0] {S_IR, S_ADDR, S_DATA} jsb_step_e;

  typedef struct packed {
    logic        tck;
    logic        tms;
    logic        tdi;
    logic        tdo_m;
    logic        tdo_s;
    logic [3:0]  div;
    jsb_hst_e    st;
    jsb_step_e   step;
    logic [4:0]  pre_tms;
    logic [2:0]  pre_n;
    logic [5:0]  cnt;
    logic [5:0]  len;
    logic [38:0] sh;
    logic [1:0]  sel;
    logic        rd;
    logic [1:0]  size;
    logic [35:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        done;
    logic        err;
    logic [1:0]  mask;
    logic        irq;
    logic [31:0] rdout;
  } jsb_host_s;

  jsb_host_s q;
  jsb_host_s d;

  logic       tick;
  logic       ev_done;
  logic       ev_err;
  logic [4:0] code;
  logic [5:0] alen;

  always_comb
  begin
    d       = q;
    ev_done = 1'b0;
    ev_err  = 1'b0;
    tick    = (q.st != H_IDLE) && (q.div == jsb_pkg::TCK_DIV_LAST);
    d.tdo_m = link.tdo;
    d.tdo_s = q.tdo_m;
    unique case (q.sel)
      jsb_pkg::SEL_DEBUG: begin code = jsb_pkg::IR_DEBUG_REG; alen = jsb_pkg::LEN_REG;   end
      jsb_pkg::SEL_MSU:   begin code = jsb_pkg::IR_MSU_REG;   alen = jsb_pkg::LEN_REG;   end
      jsb_pkg::SEL_SIZED: begin code = jsb_pkg::IR_MEM_SIZED; alen = jsb_pkg::LEN_SIZED; end
      default:            begin code = jsb_pkg::IR_MEM_WORD;  alen = jsb_pkg::LEN_WORD;  end
    endcase
    d.div = (q.st == H_IDLE || tick) ? 4'h0 : q.div + 4'h1;

    if (tick && !q.tck)
    begin
      d.tck = 1'b1;
      unique case (q.st)
        H_PRE:
        begin
          d.pre_tms = q.pre_tms >> 1;
          d.pre_n   = q.pre_n - 3'h1;
          d.cnt     = 6'h00;
          if (q.pre_n == 3'h1)
            d.st = H_SHIFT;
        end
        H_SHIFT:
        begin
          d.sh                = q.sh >> 1;
          d.sh[q.len - 6'h01] = q.tdo_s;
          d.cnt               = q.cnt + 6'h01;
          if (q.cnt == q.len - 6'h01)
            d.st = H_POST;
        end
        H_POST:
        begin
          // Now in Update; the next lead-in leaves it through Select-DR
          d.st      = H_PRE;
          d.pre_tms = jsb_pkg::PRE_DR;
          d.pre_n   = jsb_pkg::PRE_DR_N;
          d.sh      = '0;
          unique case (q.step)
            S_IR:
            begin
              d.step = S_ADDR;
              d.len  = alen;
              unique case (q.sel)
                jsb_pkg::SEL_SIZED: d.sh = {q.addr, q.size, q.rd};
                jsb_pkg::SEL_WORD:  d.sh = {4'h0, q.addr[35:2], q.rd};
                default:            d.sh = {31'h0, q.addr[6:0], q.rd};
              endcase
            end
            S_ADDR:
            begin
              if (q.sh[jsb_pkg::ADDR_BUSY])
              begin
                d.sh[jsb_pkg::SIZE_MSB + 1 + 35:0] = '0;
                unique case (q.sel)
                  jsb_pkg::SEL_SIZED: d.sh = {q.addr, q.size, q.rd};
                  jsb_pkg::SEL_WORD:  d.sh = {4'h0, q.addr[35:2], q.rd};
                  default:            d.sh = {31'h0, q.addr[6:0], q.rd};
                endcase
              end
              else
              begin
                d.step = S_DATA;
                d.sh   = {7'h0, q.wdata};
              end
            end
            default:
            begin
              if (q.sh[jsb_pkg::DATA_BUSY])
                d.sh = {7'h0, q.wdata};
              else
              begin
                d.st    = H_END;
                d.rdata = q.sh[31:0];
                ev_err  = q.sh[jsb_pkg::DATA_ERR] & q.rd;
                d.err   = q.err | ev_err;
              end
            end
          endcase
        end
        default:
        begin
          d.st    = H_IDLE;
          ev_done = 1'b1;
        end
      endcase
    end
    else if (tick)
    begin
      d.tck = 1'b0;
      d.tdi = 1'b0;
      unique case (q.st)
        H_PRE:   d.tms = q.pre_tms[0];
        H_SHIFT:
        begin
          d.tms = (q.cnt == q.len - 6'h01);
          d.tdi = q.sh[0];
        end
        H_POST:  d.tms = 1'b1;
        default: d.tms = 1'b0;
      endcase
    end

    // Register port; a status read clears, but an event in the same cycle survives
    d.rdout = 32'h0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        jsb_pkg::REG_CTRL:    d.rdout = {27'h0, q.size, q.rd, q.sel};
        jsb_pkg::REG_ADDR_LO: d.rdout = q.addr[31:0];
        jsb_pkg::REG_ADDR_HI: d.rdout = {28'h0, q.addr[35:32]};
        jsb_pkg::REG_WDATA:   d.rdout = q.wdata;
        jsb_pkg::REG_RDATA:   d.rdout = q.rdata;
        jsb_pkg::REG_STATUS:  d.rdout = {29'h0, q.st != H_IDLE, q.err, q.done};
        jsb_pkg::REG_MASK:    d.rdout = {30'h0, q.mask};
        default:              d.rdout = 32'h0;
      endcase
      if (reg_addr == jsb_pkg::REG_STATUS)
      begin
        d.done = 1'b0;
        d.err  = 1'b0;
      end
    end
    if (ev_done)
      d.done = 1'b1;
    if (ev_err)
      d.err = 1'b1;
    if (reg_wr)
    begin
      unique case (reg_addr)
        jsb_pkg::REG_CTRL:
        begin
          d.sel  = reg_wdata[1:0];
          d.rd   = reg_wdata[2];
          d.size = reg_wdata[4:3];
        end
        jsb_pkg::REG_ADDR_LO: d.addr[31:0]  = reg_wdata;
        jsb_pkg::REG_ADDR_HI: d.addr[35:32] = reg_wdata[3:0];
        jsb_pkg::REG_WDATA:   d.wdata       = reg_wdata;
        jsb_pkg::REG_MASK:    d.mask        = reg_wdata[1:0];
        jsb_pkg::REG_START:
        begin
          if (q.st == H_IDLE)
          begin
            // Each access reloads the instruction, which also forces the address phase
            d.st      = H_PRE;
            d.step    = S_IR;
            d.pre_tms = jsb_pkg::PRE_IR;
            d.pre_n   = jsb_pkg::PRE_IR_N;
            d.len     = jsb_pkg::LEN_IR;
            d.sh      = {34'h0, code};
          end
        end
        default: ;
      endcase
    end
    d.irq = |({d.err, d.done} & d.mask);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      q <= '0;
      q.st <= H_IDLE;
      q.step <= S_IR;
    end
    else
      q <= d;
  end

  assign link.tck  = q.tck;
  assign link.tms  = q.tms;
  assign link.tdi  = q.tdi;
  assign reg_rdata = q.rdout;
  assign irq       = q.irq;
endmodule
`default_nettype wire

// *** verif/jsb_link_sva.sv ***
// Checker on the link wires and the service bus master of the device.
// Assumes the bench instantiates it beside the link interface.
`default_nettype none
module jsb_link_sva (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // Link
  input wire logic        tck,
  input wire logic        tms,
  input wire logic        tdo,
  // Service bus
  input wire logic        sab_req,
  input wire logic [1:0]  sab_unit,
  input wire logic [35:0] sab_addr,
  input wire logic        sab_write,
  input wire logic [3:0]  sab_be,
  input wire logic        sab_ack
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  sequence wait_s;
    sab_req && !sab_ack;
  endsequence
  sequence done_s;
    sab_req && sab_ack;
  endsequence
  sequence mem_s;
    sab_req && sab_unit == jsb_pkg::UNIT_MEM;
  endsequence
  req_hold_a: assert property (wait_s |=> sab_req && $stable({sab_unit, sab_addr, sab_write, sab_be}))
    else $error("bus request changed while waiting");
  req_drop_a: assert property (done_s |=> !sab_req)
    else $error("bus request stayed after ack");
  word_lane_a: assert property (mem_s ##0 sab_be == 4'hf |-> sab_addr[1:0] == 2'h0)
    else $error("word access not aligned");
  half_lane_a: assert property (mem_s ##0 sab_be inside {4'h3, 4'hc} |-> sab_be == 4'(4'h3 << sab_addr[1:0]))
    else $error("halfword lanes wrong");
  byte_lane_a: assert property (mem_s ##0 $onehot(sab_be) |-> sab_be == 4'(4'h1 << sab_addr[1:0]))
    else $error("byte lane wrong");
  index_range_a: assert property (sab_req && sab_unit != jsb_pkg::UNIT_MEM |-> sab_addr[35:7] == 29'h0)
    else $error("register index too wide");
  tck_high_a: assert property ($rose(tck) |=> tck [*7])
    else $error("test clock high phase short");
  tms_steady_a: assert property ($rose(tck) |-> $stable(tms))
    else $error("mode select moved at clock rise");
  tdo_fall_a: assert property ($changed(tdo) |-> !tck)
    else $error("data out moved while clock high");
endmodule
`default_nettype wire

// *** verif/test_jsb_service_bus_access.sv ***
// Bench: host and device joined by the link; the bench is the bus target.
// Assumes the package, interface and both ends compile first.
`default_nettype none
module test_jsb_service_bus_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, reset, reg_wr, reg_rd, irq, sab_req, sab_write, sab_ack, sab_err;
  logic [3:0]  reg_addr, sab_be;
  logic [31:0] reg_wdata, reg_rdata, sab_rdata, sab_wdata, d;
  logic [1:0]  sab_unit;
  logic [35:0] sab_addr;
  int          miscompares, check_count, k;
  bit          req_seen, irq_seen;
  jsb_link_if link ();
  jsb_dev jsb_dev_inst (.mclk(mclk), .reset(reset), .link(link), .sab_req(sab_req), .sab_unit(sab_unit),
    .sab_addr(sab_addr), .sab_write(sab_write), .sab_be(sab_be), .sab_wdata(sab_wdata), .sab_ack(sab_ack),
    .sab_err(sab_err), .sab_rdata(sab_rdata));
  jsb_host jsb_host_inst (.mclk(mclk), .reset(reset), .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  jsb_link_sva jsb_link_sva_inst (.mclk(mclk), .reset(reset), .tck(link.tck), .tms(link.tms), .tdo(link.tdo),
    .sab_req(sab_req), .sab_unit(sab_unit), .sab_addr(sab_addr), .sab_write(sab_write), .sab_be(sab_be),
    .sab_ack(sab_ack));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (sab_req === 1'b1) req_seen <= 1'b1;
    if (irq === 1'b1) irq_seen <= 1'b1;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [35:0] e, logic [35:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic hang();
    miscompares++;
    tally_and_finish();
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Control word is {size, read, select}
  task automatic run(logic [4:0] c, logic [35:0] a, logic [31:0] w);
    req_seen = 1'b0;
    irq_seen = 1'b0;
    wr(jsb_pkg::REG_CTRL, {27'h0, c});
    wr(jsb_pkg::REG_ADDR_LO, a[31:0]);
    wr(jsb_pkg::REG_ADDR_HI, {28'h0, a[35:32]});
    wr(jsb_pkg::REG_WDATA, w);
    wr(jsb_pkg::REG_START, 32'h0);
  endtask
  // A long lag makes the next data scan capture busy, forcing a repeat
  task automatic serve(logic [1:0] u, logic [35:0] a, logic w, logic [3:0] b, logic [31:0] v, logic e, int lag);
    int i;
    for (i = 0; i < 5000 && sab_req !== 1'b1; i++) @(posedge mclk);
    if (i == 5000) hang();
    #1;
    chk("unit", u, sab_unit);
    chk("addr", a, sab_addr);
    chk("write", !w, sab_write);
    if (u == jsb_pkg::UNIT_MEM) chk("lanes", b, sab_be);
    if (!w) chk("wdata", v, sab_wdata);
    // Ack is driven on an edge, never a step after it
    repeat (lag + 1) @(posedge mclk);
    sab_ack <= 1'b1;
    sab_rdata <= v;
    sab_err <= e;
    @(posedge mclk);
    sab_ack <= 1'b0;
  endtask
  task automatic done(logic [1:0] e);
    int i;
    logic [1:0] s;
    s = 2'h0;
    for (i = 0; i < 3000; i++)
    begin
      rd(jsb_pkg::REG_STATUS);
      // Error may be read, and so cleared, before done is set
      s = s | d[1:0];
      if (d[0] === 1'b1) break;
    end
    if (i == 3000) hang();
    chk("status", e, s);
  endtask
  task automatic irq_done(logic [1:0] e);
    int i;
    for (i = 0; i < 5000 && irq !== 1'b1; i++) @(posedge mclk);
    if (i == 5000) hang();
    done(e);
    repeat (2) @(posedge mclk);
    chk("irq", 1'b0, irq);
  endtask
  task automatic t_debug_read();
    wr(jsb_pkg::REG_MASK, 32'h3);
    run({3'h1, jsb_pkg::SEL_DEBUG}, 36'h5a, 32'h0);
    serve(jsb_pkg::UNIT_DEBUG, 36'h5a, 1'b1, 4'h0, 32'hcafe0123, 1'b0, 400);
    irq_done(2'h1);
    rd(jsb_pkg::REG_RDATA);
    chk("rdata", 32'hcafe0123, d);
  endtask
  task automatic t_msu_write();
    wr(jsb_pkg::REG_MASK, 32'h0);
    run({3'h0, jsb_pkg::SEL_MSU}, 36'h7f, 32'h12345678);
    serve(jsb_pkg::UNIT_MSU, 36'h7f, 1'b0, 4'h0, 32'h12345678, 1'b0, 0);
    done(2'h1);
    chk("masked irq", 1'b0, irq_seen);
    rd(4'hf);
    chk("unmapped", 32'h0, d);
    wr(jsb_pkg::REG_MASK, 32'h3);
  endtask
  task automatic t_sized();
    for (k = 0; k < 4; k++)
    begin
      run({jsb_pkg::SIZE_BYTE, 1'b0, jsb_pkg::SEL_SIZED}, 36'h900001000 + k, 32'ha5 << (8 * k));
      serve(jsb_pkg::UNIT_MEM, 36'h900001000 + k, 1'b0, 4'h1 << k, 32'ha5 << (8 * k), 1'b0, 0);
      done(2'h1);
    end
    run({jsb_pkg::SIZE_HALF, 1'b1, jsb_pkg::SEL_SIZED}, 36'h900001002, 32'h0);
    serve(jsb_pkg::UNIT_MEM, 36'h900001002, 1'b1, 4'hc, 32'hbeef0000, 1'b0, 0);
    done(2'h1);
    rd(jsb_pkg::REG_RDATA);
    chk("half rdata", 32'hbeef0000, d);
    run({jsb_pkg::SIZE_WORD, 1'b1, jsb_pkg::SEL_SIZED}, 36'h900001004, 32'h0);
    serve(jsb_pkg::UNIT_MEM, 36'h900001004, 1'b1, 4'hf, 32'h600dcafe, 1'b0, 0);
    done(2'h1);
    rd(jsb_pkg::REG_RDATA);
    chk("word rdata", 32'h600dcafe, d);
  endtask
  task automatic t_word_err();
    run({3'h1, jsb_pkg::SEL_WORD}, 36'h876543210, 32'h0);
    serve(jsb_pkg::UNIT_MEM, 36'h876543210, 1'b1, 4'hf, 32'h0, 1'b1, 0);
    irq_done(2'h3);
  endtask
  task automatic t_refused();
    run({jsb_pkg::SIZE_HALF, 1'b1, jsb_pkg::SEL_SIZED}, 36'h900001001, 32'h0);
    done(2'h3);
    chk("no request", 1'b0, req_seen);
    run({jsb_pkg::SIZE_RSVD, 1'b1, jsb_pkg::SEL_SIZED}, 36'h900001000, 32'h0);
    done(2'h3);
    chk("no request", 1'b0, req_seen);
  endtask
  initial
  begin
    reset = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sab_ack = 1'b0;
    sab_err = 1'b0;
    sab_rdata = 32'h0;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    t_debug_read();
    t_msu_write();
    t_sized();
    t_word_err();
    t_refused();
    tally_and_finish();
  end
endmodule
`default_nettype wire
